/* File: bench/tb_top.sv */
`timescale 1ns/100ps
module tb_top;
   logic mclk = 1'b0;
   logic srst = 1'b1;
   logic [15:0] av_address = 16'h0000;
   logic av_read = 1'b0;
   logic av_write = 1'b0;
   logic [31:0] av_writedata = 32'h0000_0000;
   logic [31:0] av_readdata;
   logic av_waitrequest;
   logic irq;
   logic [7:0] opt = 8'h00;
   logic stop_req = 1'b0;
   logic boot_pin = 1'b0;
   logic hold_low = 1'b0;
   logic pin_n, pin_out, pin_oe, sys_rst, bus_clk_en;
   logic [31:0] rd;
   int fail_count = 0;
   int checked = 0;
   int seed = 7;
   int rst_cnt = 0;
   int exp_st = 0;
   int n;

   // 40 MHz core clock, bus clock 20 MHz, far above the monitor floor
   always #12.5 mclk = ~mclk;
   always @(posedge mclk) if (sys_rst === 1'b1) rst_cnt <= rst_cnt + 1;

   wdg_top #(.WDG_TIMEOUT_BUS(16)) dut_u (.mclk(mclk), .srst(srst), .av_address(av_address),
      .av_read(av_read), .av_write(av_write), .av_writedata(av_writedata),
      .av_byteenable(4'hF), .av_readdata(av_readdata), .av_waitrequest(av_waitrequest),
      .irq(irq), .first_option_register(opt), .stop_req(stop_req),
      .boot_mode_pin(boot_pin), .rst_pin_n_in(pin_n), .rst_pin_n_out(pin_out),
      .rst_pin_n_oe(pin_oe), .sys_rst(sys_rst), .bus_clk_en(bus_clk_en));

   wdg_pin_model pm_u (.hold_low(hold_low), .dev_oe(pin_oe), .dev_out(pin_out), .pin_n(pin_n));

   task stop_test;
      if (fail_count == 0 && checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : stop_test

   task chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         fail_count++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task bus(input logic wr, input logic [15:0] a, input logic [31:0] d);
      int i;
      @(posedge mclk);
      av_address <= a;
      av_writedata <= d;
      av_write <= wr;
      av_read <= !wr;
      i = 0;
      do begin
         @(posedge mclk);
         i++;
      end while (av_waitrequest !== 1'b0 && i < 50);
      if (i >= 50) begin
         fail_count++;
         stop_test;
      end
      rd = av_readdata;
      av_write <= 1'b0;
      av_read <= 1'b0;
   endtask : bus

   task rd_chk(input logic [15:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0000_0000);
      chk(rd, exp);
   endtask : rd_chk

   // waits for a system reset, then measures how long the pin is driven
   task wait_rst(input int lim, output int len);
      int i;
      i = 0;
      len = 0;
      while (sys_rst !== 1'b1 && i < lim) begin
         @(posedge mclk);
         i++;
      end
      if (i >= lim) begin
         fail_count++;
         stop_test;
      end
      while (pin_oe === 1'b1 && len < 50) begin
         @(posedge mclk);
         len++;
      end
   endtask : wait_rst

   initial begin
      repeat (2) @(posedge mclk);
      srst <= 1'b0;
      opt <= 8'($random(seed)) & 8'hFE;
      repeat (3) @(posedge mclk);
      rd_chk(wdg_pkg::ADDR_CLEAR, {24'h000000, opt});
      rd_chk(wdg_pkg::ADDR_CTRL, 32'h0000_0000);
      rd_chk(wdg_pkg::ADDR_STATUS, 32'h0000_0000);
      rd_chk(wdg_pkg::ADDR_MASK, 32'h0000_0000);
      rd_chk(16'h1FE0, 32'h0000_0000);
      chk(irq, 1'b0);
      n = 0;
      repeat (40) begin
         @(posedge mclk);
         if (bus_clk_en === 1'b1) n++;
      end
      chk(n, 20);
      // watchdog kept alive by clearing writes, then left to expire
      opt <= opt | 8'h01;
      n = rst_cnt;
      repeat (8) begin
         repeat (10) @(posedge mclk);
         bus(1'b1, wdg_pkg::ADDR_CLEAR, 32'h0000_0000);
      end
      chk(rst_cnt - n, 0);
      // writes of one must not restart it: expiry 16 bus cycles after the last zero
      repeat (3) bus(1'b1, wdg_pkg::ADDR_CLEAR, 32'h0000_0001);
      wait_rst(28, n);
      opt <= opt & 8'hFE;
      chk(n, 4 * 2);
      exp_st = exp_st | 1;
      rd_chk(wdg_pkg::ADDR_STATUS, exp_st);
      bus(1'b1, wdg_pkg::ADDR_MASK, 32'h0000_0007);
      repeat (2) @(posedge mclk);
      chk(irq, 1'b1);
      bus(1'b1, wdg_pkg::ADDR_STATUS, 32'h0000_0001);
      exp_st = 0;
      repeat (2) @(posedge mclk);
      chk(irq, 1'b0);
      rd_chk(wdg_pkg::ADDR_STATUS, exp_st);
      // bootloader mode keeps the watchdog quiet
      boot_pin <= 1'b1;
      opt <= opt | 8'h01;
      repeat (4) @(posedge mclk);
      n = rst_cnt;
      repeat (150) @(posedge mclk);
      chk(rst_cnt - n, 0);
      rd_chk(wdg_pkg::ADDR_STATUS, 32'h0000_0010);
      boot_pin <= 1'b0;
      opt <= opt & 8'hFE;
      // halted clock without monitor enable is harmless
      stop_req <= 1'b1;
      n = rst_cnt;
      repeat (300) @(posedge mclk);
      chk(rst_cnt - n, 0);
      stop_req <= 1'b0;
      bus(1'b1, wdg_pkg::ADDR_CTRL, 32'h0000_0001);
      rd_chk(wdg_pkg::ADDR_CTRL, 32'h0000_0001);
      stop_req <= 1'b1;
      wait_rst(300, n);
      stop_req <= 1'b0;
      chk(n, 4 * 2);
      exp_st = exp_st | 2;
      rd_chk(wdg_pkg::ADDR_STATUS, exp_st);
      chk(irq, 1'b1);
      bus(1'b1, wdg_pkg::ADDR_STATUS, 32'h0000_0002);
      exp_st = 0;
      // outside party holds the line low
      hold_low <= 1'b1;
      repeat (12) @(posedge mclk);
      chk(sys_rst, 1'b1);
      chk(pin_oe, 1'b0);
      hold_low <= 1'b0;
      repeat (6) @(posedge mclk);
      chk(sys_rst, 1'b0);
      exp_st = exp_st | 4;
      rd_chk(wdg_pkg::ADDR_STATUS, exp_st);
      stop_test;
   end
endmodule : tb_top

/* File: bench/wdg_pin_model.sv */
`timescale 1ns/100ps
module wdg_pin_model (
   // bench control
   input wire logic hold_low,
   // device side of the pin
   input wire logic dev_oe,
   input wire logic dev_out,
   // resolved line
   output logic pin_n
);
   // open-drain line with pull-up, low if either party pulls
   always_comb begin
      pin_n = 1'b1;
      if (dev_oe && !dev_out) pin_n = 1'b0;
      if (hold_low) pin_n = 1'b0;
   end
endmodule : wdg_pin_model

/* File: inc/wdg_pkg.sv */
package wdg_pkg;
   // register byte addresses
   localparam logic [15:0] ADDR_CLEAR = 16'h1FF0;
   localparam logic [15:0] ADDR_CTRL = 16'h1FF4;
   localparam logic [15:0] ADDR_STATUS = 16'h1FF8;
   localparam logic [15:0] ADDR_MASK = 16'h1FFC;
   // field positions
   localparam int CLEAR_BIT = 0;
   localparam int OPT_WDG_EN_BIT = 0;
   localparam int CTRL_CM_EN_BIT = 0;
   localparam int EV_WDG = 0;
   localparam int EV_CM = 1;
   localparam int EV_EXT = 2;
   localparam int EV_NUM = 3;
   localparam int STATUS_BOOT_BIT = 4;
   // values after reset
   localparam logic CM_EN_RST = 1'b0;
   localparam logic [2:0] EV_RST = 3'h0;
   localparam logic [2:0] MASK_RST = 3'h0;
   // timing
   localparam int CLK_PERIOD_NS = 25;
   localparam int BUS_DIV = 2;
   localparam int CM_TIMEOUT_NS = 5000;
   localparam int CM_TIMEOUT_CYC = CM_TIMEOUT_NS / CLK_PERIOD_NS;
   localparam int RST_DRIVE_BUS = 4;
   localparam int RST_DRIVE_CYC = RST_DRIVE_BUS * BUS_DIV;
   localparam int RST_GUARD_CYC = 3;
   localparam int WDG_TIMEOUT_BUS = 262144;
   localparam int SYNC_STAGES = 2;

   typedef enum logic [1:0] {
      RST_IDLE = 2'b00,
      RST_DRIVE = 2'b01,
      RST_GUARD = 2'b10
   } rst_state_type;
endpackage : wdg_pkg

/* File: inc/wdg_reg_if.sv */
`timescale 1ns/100ps
interface wdg_reg_if;
   logic wr;
   logic [15:0] addr;
   logic [31:0] wdata;
   logic [3:0] be;
   logic [31:0] rdata;
   modport bus (output wr, output addr, output wdata, output be, input rdata);
   modport core (input wr, input addr, input wdata, input be, output rdata);
endinterface : wdg_reg_if

/* File: verilog/wdg_avs.sv */
`timescale 1ns/100ps
module wdg_avs (
   // clock and reset
   input wire logic mclk,
   input wire logic srst,
   // avalon-mm slave
   input wire logic [15:0] av_address,
   input wire logic av_read,
   input wire logic av_write,
   input wire logic [31:0] av_writedata,
   input wire logic [3:0] av_byteenable,
   output logic [31:0] av_readdata,
   output logic av_waitrequest,
   // register side
   wdg_reg_if.bus regs
);
   logic wait_q;
   logic wait_d;
   logic [31:0] rdata_q;
   logic [31:0] rdata_d;
   logic req;

   // one wait cycle, then accept on the edge that sees waitrequest low
   always_comb begin
      req = av_read | av_write;
      wait_d = ~(req & wait_q);
      rdata_d = rdata_q;
      if (av_read && wait_q) begin
         rdata_d = regs.rdata;
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         wait_q <= 1'b1;
         rdata_q <= 32'h0;
      end else begin
         wait_q <= wait_d;
         rdata_q <= rdata_d;
      end
   end

   assign regs.wr = av_write & ~wait_q;
   assign regs.addr = av_address;
   assign regs.wdata = av_writedata;
   assign regs.be = av_byteenable;
   assign av_waitrequest = wait_q;
   assign av_readdata = rdata_q;
endmodule : wdg_avs

/* File: verilog/wdg_sync.sv */
`timescale 1ns/100ps
module wdg_sync #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] INIT = '0
) (
   // clock and reset
   input wire logic mclk,
   input wire logic srst,
   // levels
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] meta_d;
   logic [WIDTH-1:0] sync_q;
   logic [WIDTH-1:0] sync_d;

   always_comb begin
      meta_d = async_in;
      sync_d = meta_q;
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         meta_q <= INIT;
         sync_q <= INIT;
      end else begin
         meta_q <= meta_d;
         sync_q <= sync_d;
      end
   end

   assign sync_out = sync_q;
endmodule : wdg_sync

/* File: verilog/wdg_top.sv */
`timescale 1ns/100ps
module wdg_top #(
   parameter int WDG_TIMEOUT_BUS = wdg_pkg::WDG_TIMEOUT_BUS
) (
   // clock and reset
   input wire logic mclk,
   input wire logic srst,
   // avalon-mm slave
   input wire logic [15:0] av_address,
   input wire logic av_read,
   input wire logic av_write,
   input wire logic [31:0] av_writedata,
   input wire logic [3:0] av_byteenable,
   output logic [31:0] av_readdata,
   output logic av_waitrequest,
   // interrupt
   output logic irq,
   // device context
   input wire logic [7:0] first_option_register,
   input wire logic stop_req,
   input wire logic boot_mode_pin,
   // reset pin
   input wire logic rst_pin_n_in,
   output logic rst_pin_n_out,
   output logic rst_pin_n_oe,
   // system outputs
   output logic sys_rst,
   output logic bus_clk_en
);
   localparam int WW = $clog2(WDG_TIMEOUT_BUS);
   localparam logic [WW-1:0] WDG_LAST = WW'(WDG_TIMEOUT_BUS - 1);
   localparam logic [7:0] CM_LAST = 8'(wdg_pkg::CM_TIMEOUT_CYC - 1);
   localparam logic [3:0] DRV_LAST = 4'(wdg_pkg::RST_DRIVE_CYC - 1);
   localparam logic [3:0] GRD_LAST = 4'(wdg_pkg::RST_GUARD_CYC - 1);
   localparam int CM_BOUND = 210;

   function automatic logic hit(input logic [15:0] a, input logic [15:0] off);
      hit = (a[15:2] == off[15:2]);
   endfunction : hit

   wdg_reg_if regs ();

   wdg_avs u_avs (
      .mclk(mclk),
      .srst(srst),
      .av_address(av_address),
      .av_read(av_read),
      .av_write(av_write),
      .av_writedata(av_writedata),
      .av_byteenable(av_byteenable),
      .av_readdata(av_readdata),
      .av_waitrequest(av_waitrequest),
      .regs(regs)
   );

   logic pin_n_s;
   logic boot_s;

   wdg_sync #(.WIDTH(2), .INIT(2'h1)) u_sync (
      .mclk(mclk),
      .srst(srst),
      .async_in({boot_mode_pin, rst_pin_n_in}),
      .sync_out({boot_s, pin_n_s})
   );

   // bus clock divider
   logic div_q;
   logic div_d;
   logic bus_en_q;
   logic bus_en_d;

   always_comb begin
      div_d = ~div_q;
      bus_en_d = div_q & ~stop_req;
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         div_q <= 1'b0;
         bus_en_q <= 1'b0;
      end else begin
         div_q <= div_d;
         bus_en_q <= bus_en_d;
      end
   end

   // register strobes
   logic int_rst;
   logic clear_wr;
   logic wdg_active;

   always_comb begin
      clear_wr = regs.wr && hit(regs.addr, wdg_pkg::ADDR_CLEAR) && regs.be[0]
                 && !regs.wdata[wdg_pkg::CLEAR_BIT];
      wdg_active = first_option_register[wdg_pkg::OPT_WDG_EN_BIT] && !boot_s;
   end

   // fixed watchdog
   logic [WW-1:0] wdg_cnt_q;
   logic [WW-1:0] wdg_cnt_d;
   logic wdg_exp;

   always_comb begin
      wdg_cnt_d = wdg_cnt_q;
      wdg_exp = wdg_active && bus_en_q && (wdg_cnt_q == WDG_LAST);
      if (!wdg_active || clear_wr || int_rst || wdg_exp) begin
         wdg_cnt_d = '0;
      end else if (bus_en_q) begin
         wdg_cnt_d = wdg_cnt_q + 1'b1;
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         wdg_cnt_q <= '0;
      end else begin
         wdg_cnt_q <= wdg_cnt_d;
      end
   end

   // clock monitor
   logic cm_en_q;
   logic cm_en_d;
   logic [7:0] cm_cnt_q;
   logic [7:0] cm_cnt_d;
   logic cm_exp;

   always_comb begin
      cm_en_d = cm_en_q;
      if (int_rst) begin
         cm_en_d = wdg_pkg::CM_EN_RST;
      end else if (regs.wr && hit(regs.addr, wdg_pkg::ADDR_CTRL) && regs.be[0]) begin
         cm_en_d = regs.wdata[wdg_pkg::CTRL_CM_EN_BIT];
      end
      cm_exp = cm_en_q && (cm_cnt_q == CM_LAST);
      cm_cnt_d = cm_cnt_q + 8'h01;
      if (!cm_en_q || bus_en_q || cm_exp) begin
         cm_cnt_d = 8'h00;
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         cm_en_q <= wdg_pkg::CM_EN_RST;
         cm_cnt_q <= 8'h00;
      end else begin
         cm_en_q <= cm_en_d;
         cm_cnt_q <= cm_cnt_d;
      end
   end

   // reset pin sequencer
   wdg_pkg::rst_state_type st_q;
   wdg_pkg::rst_state_type st_d;
   logic [3:0] rcnt_q;
   logic [3:0] rcnt_d;
   logic oe_q;
   logic oe_d;
   logic srst_q;
   logic srst_d;
   logic ext_low;

   always_comb begin
      st_d = st_q;
      rcnt_d = rcnt_q + 4'h1;
      ext_low = (st_q == wdg_pkg::RST_IDLE) && !pin_n_s;
      case (st_q)
         wdg_pkg::RST_IDLE: begin
            rcnt_d = 4'h0;
            if (wdg_exp || cm_exp) begin
               st_d = wdg_pkg::RST_DRIVE;
            end
         end
         wdg_pkg::RST_DRIVE: begin
            if (rcnt_q == DRV_LAST) begin
               st_d = wdg_pkg::RST_GUARD;
               rcnt_d = 4'h0;
            end
         end
         wdg_pkg::RST_GUARD: begin
            // own drive still in the synchroniser
            if (rcnt_q == GRD_LAST) begin
               st_d = wdg_pkg::RST_IDLE;
               rcnt_d = 4'h0;
            end
         end
         default: begin
            st_d = wdg_pkg::RST_IDLE;
            rcnt_d = 4'h0;
         end
      endcase
      oe_d = (st_d == wdg_pkg::RST_DRIVE);
      srst_d = oe_d || ext_low;
      int_rst = srst_q;
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         st_q <= wdg_pkg::RST_IDLE;
         rcnt_q <= 4'h0;
         oe_q <= 1'b0;
         srst_q <= 1'b0;
      end else begin
         st_q <= st_d;
         rcnt_q <= rcnt_d;
         oe_q <= oe_d;
         srst_q <= srst_d;
      end
   end

   // sticky events and interrupt
   logic [2:0] ev_q;
   logic [2:0] ev_d;
   logic [2:0] mask_q;
   logic [2:0] mask_d;
   logic irq_q;
   logic irq_d;
   logic [2:0] ev_set;
   logic [2:0] ev_clr;

   always_comb begin
      ev_set = 3'h0;
      ev_set[wdg_pkg::EV_WDG] = wdg_exp;
      ev_set[wdg_pkg::EV_CM] = cm_exp;
      ev_set[wdg_pkg::EV_EXT] = ext_low && !srst_q;
      ev_clr = 3'h0;
      mask_d = mask_q;
      if (regs.wr && regs.be[0] && hit(regs.addr, wdg_pkg::ADDR_STATUS)) begin
         ev_clr = regs.wdata[2:0];
      end
      if (regs.wr && regs.be[0] && hit(regs.addr, wdg_pkg::ADDR_MASK)) begin
         mask_d = regs.wdata[2:0];
      end
      ev_d = (ev_q & ~ev_clr) | ev_set;
      irq_d = |(ev_d & mask_d);
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         ev_q <= wdg_pkg::EV_RST;
         mask_q <= wdg_pkg::MASK_RST;
         irq_q <= 1'b0;
      end else begin
         ev_q <= ev_d;
         mask_q <= mask_d;
         irq_q <= irq_d;
      end
   end

   // read decode
   always_comb begin
      regs.rdata = 32'h0;
      if (hit(regs.addr, wdg_pkg::ADDR_CLEAR)) begin
         regs.rdata[7:0] = first_option_register;
      end else if (hit(regs.addr, wdg_pkg::ADDR_CTRL)) begin
         regs.rdata[wdg_pkg::CTRL_CM_EN_BIT] = cm_en_q;
      end else if (hit(regs.addr, wdg_pkg::ADDR_STATUS)) begin
         regs.rdata[2:0] = ev_q;
         regs.rdata[wdg_pkg::STATUS_BOOT_BIT] = boot_s;
      end else if (hit(regs.addr, wdg_pkg::ADDR_MASK)) begin
         regs.rdata[2:0] = mask_q;
      end
   end

   assign irq = irq_q;
   assign rst_pin_n_out = 1'b0;
   assign rst_pin_n_oe = oe_q;
   assign sys_rst = srst_q;
   assign bus_clk_en = bus_en_q;

   // checks
   a_bus_half_rate: assert property (@(posedge mclk) disable iff (srst)
      bus_en_q |=> !bus_en_q) else $error("bus enable faster than half rate");
   a_clear_restart: assert property (@(posedge mclk) disable iff (srst)
      clear_wr |=> wdg_cnt_q == '0) else $error("clear did not restart watchdog");
   a_boot_wdg_off: assert property (@(posedge mclk) disable iff (srst)
      (boot_s && $past(boot_s)) |-> (wdg_cnt_q == '0 && !wdg_exp))
      else $error("watchdog ran in boot mode");
   a_wdg_expire_rst: assert property (@(posedge mclk) disable iff (srst)
      wdg_exp |=> oe_q && sys_rst) else $error("expiry gave no reset");
   a_drive_four_bus: assert property (@(posedge mclk) disable iff (srst)
      $rose(oe_q) |-> oe_q[*8] ##1 !oe_q) else $error("pin drive length wrong");
   a_stop_monitor: assert property (@(posedge mclk) disable iff (srst)
      (cm_en_q && stop_req && st_q == wdg_pkg::RST_IDLE && !sys_rst)[*2]
      |-> ##[1:CM_BOUND] oe_q) else $error("stop gave no reset");
   a_ext_pin_rst: assert property (@(posedge mclk) disable iff (srst)
      ext_low |=> sys_rst) else $error("external reset missed");
   a_rd_option: assert property (@(posedge mclk) disable iff (srst)
      (av_read && av_waitrequest && hit(av_address, wdg_pkg::ADDR_CLEAR))
      |=> av_readdata[7:0] == $past(first_option_register))
      else $error("clear address read wrong");
   a_irq_level: assert property (@(posedge mclk) disable iff (srst)
      irq == |(ev_q & mask_q)) else $error("interrupt level wrong");
endmodule : wdg_top
